// [verilog/ltssm_timers_lanes.sv]
// lane order mux and training-state timers of the link training logic
//
// Function
// - lane reverse input high attaches transceiver channels in reversed order.
// - reversed x4: channel 3 feeds lane 0, down to channel 0 lane 3.
// - reversal ignored in single-lane mode; chosen channel is only lane.
// - loopback slave waits 1 ms (800 ns sim) for electrical idle after idle set.
// - Polling.Active sends 1024 TS1 sets, 48 in simulation.
// - loopback master timeout 100 ms, 4000 ns in simulation.
// - state exit timers 12, 24, 48 and 2 ms per training state.
// - simulation shortens timers to 800, 1600, 3200, 1200 ns and 20 us.
// - late configuration still trains: Detect, then follow partner to Polling.
`timescale 1ns/1ns
module ltssm_timers_lanes
    import ltssm_timer_pkg::*;
#(
    parameter bit SIMULATE = 1'b0
) (
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    input  wire logic        flip_lanes_i,
    input  wire logic        single_lane_i,
    input  wire logic [1:0]  single_chan_i,
    input  wire lane_bus_t   serdes_rx_i,
    input  wire link_event_t link_event_i,
    input  wire logic        ts1_sent_i,
    input  wire logic        lb_slave_start_i,
    input  wire logic        lb_master_start_i,
    input  wire logic        cpl_pending_i,
    output lane_bus_t        lane_rx_o,
    output train_state_t     state_o,
    output logic             lb_idle_timeout_o,
    output logic             lb_master_timeout_o,
    output logic             cpl_timeout_o
);

    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // lane order

    // single-lane selection overrides reversal, so a stray flip strap is harmless there
    function automatic logic [1:0] src_chan(input logic [1:0] lane, input logic flip,
                                            input logic single, input logic [1:0] sel);
        return single ? sel : (flip ? 2'h3 - lane : lane);
    endfunction

    genvar gl;
    generate
        for (gl = 0; gl < LANES; gl++) begin : g_lane
            always_ff @(posedge clock_i or negedge rst_sync_q) begin
                if (!rst_sync_q) begin
                    lane_rx_o.data[gl]  <= '0;
                    lane_rx_o.valid[gl] <= 1'b0;
                end else if (single_lane_i && gl != 0) begin
                    lane_rx_o.data[gl]  <= '0;
                    lane_rx_o.valid[gl] <= 1'b0;
                end else begin
                    lane_rx_o.data[gl]  <= serdes_rx_i.data[src_chan(2'(gl), flip_lanes_i,
                                            single_lane_i, single_chan_i)];
                    lane_rx_o.valid[gl] <= serdes_rx_i.valid[src_chan(2'(gl), flip_lanes_i,
                                            single_lane_i, single_chan_i)];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // timer limits, chosen once by the simulation option

    localparam logic [CNT_W-1:0] LIM_QUIET  = CNT_W'(SIMULATE ? DETECT_QUIET_SIM_CYC
                                                               : DETECT_QUIET_CYC);
    localparam logic [CNT_W-1:0] LIM_24     = CNT_W'(SIMULATE ? POLL_ACTIVE_SIM_CYC
                                                               : POLL_ACTIVE_CYC);
    localparam logic [CNT_W-1:0] LIM_48     = CNT_W'(SIMULATE ? POLL_CONFIG_SIM_CYC
                                                               : POLL_CONFIG_CYC);
    localparam logic [CNT_W-1:0] LIM_IDLE   = CNT_W'(SIMULATE ? CFG_IDLE_SIM_CYC
                                                               : CFG_IDLE_CYC);
    localparam logic [CNT_W-1:0] LIM_CPL    = CNT_W'(SIMULATE ? CPL_TIMEOUT_SIM_CYC
                                                               : CPL_TIMEOUT_CYC);
    localparam logic [CNT_W-1:0] LIM_LBM    = CNT_W'(SIMULATE ? LB_MASTER_SIM_CYC
                                                               : LB_MASTER_CYC);
    localparam logic [CNT_W-1:0] LIM_LBS    = CNT_W'(SIMULATE ? LB_IDLE_WAIT_SIM_CYC
                                                               : LB_IDLE_WAIT_CYC);
    localparam logic [10:0]      LIM_TS1    = 11'(SIMULATE ? TS1_COUNT_SIM
                                                           : TS1_COUNT_NORMAL);

    ////////////////////////////////////////////////////////////////////////////
    // training state machine

    train_state_t     state_q;
    train_state_t     state_d;
    logic [CNT_W-1:0] state_timer_q;
    logic [CNT_W-1:0] state_limit;
    logic [10:0]      polling_training_set_count_q;
    logic             timer_done;

    always_comb begin
        case (state_q)
            ST_DETECT_QUIET:  state_limit = LIM_QUIET;
            ST_POLL_ACTIVE,
            ST_CFG_LINKWIDTH,
            ST_RCVRY_LOCK:    state_limit = LIM_24;
            ST_POLL_CONFIG,
            ST_RCVRY_CFG:     state_limit = LIM_48;
            ST_CFG_IDLE:      state_limit = LIM_IDLE;
            default:          state_limit = '1;
        endcase
    end

    assign timer_done = (state_timer_q >= state_limit - 1'b1);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_DETECT_QUIET: if (!link_event_i.rx_elec_idle || timer_done) begin
                state_d = ST_DETECT_ACTIVE;
            end
            // a late-configured core still finds the partner here
            ST_DETECT_ACTIVE: state_d = link_event_i.receiver_found ? ST_POLL_ACTIVE
                                            : ST_DETECT_QUIET;
            ST_POLL_ACTIVE: if (polling_training_set_count_q >= LIM_TS1 &&
                                (link_event_i.rx_ts1 || link_event_i.rx_ts2)) begin
                state_d = ST_POLL_CONFIG;
            end else if (timer_done) begin
                state_d = ST_DETECT_QUIET;
            end
            ST_POLL_CONFIG: if (link_event_i.rx_ts2) begin
                state_d = ST_CFG_LINKWIDTH;
            end else if (timer_done) begin
                state_d = ST_DETECT_QUIET;
            end
            ST_CFG_LINKWIDTH: if (link_event_i.link_ok) begin
                state_d = ST_CFG_IDLE;
            end else if (timer_done) begin
                state_d = ST_DETECT_QUIET;
            end
            ST_CFG_IDLE, ST_RCVRY_CFG: if (link_event_i.rx_idle_set) begin
                state_d = ST_L0;
            end else if (timer_done) begin
                state_d = ST_DETECT_QUIET;
            end
            ST_L0: if (link_event_i.retrain) begin
                state_d = ST_RCVRY_LOCK;
            end
            ST_RCVRY_LOCK: if (link_event_i.rx_ts1 || link_event_i.rx_ts2) begin
                state_d = ST_RCVRY_CFG;
            end else if (timer_done) begin
                state_d = ST_DETECT_QUIET;
            end
            default: state_d = ST_DETECT_QUIET;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            state_q <= ST_DETECT_QUIET;
        end else begin
            state_q <= state_d;
        end
    end

    // timer cleared on every state change so each state gets its full time
    always_ff @(posedge clock_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            state_timer_q <= '0;
        end else if (state_d != state_q) begin
            state_timer_q <= '0;
        end else if (!timer_done) begin
            state_timer_q <= state_timer_q + 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            polling_training_set_count_q <= '0;
        end else if (state_q != ST_POLL_ACTIVE) begin
            polling_training_set_count_q <= '0;
        end else if (ts1_sent_i && polling_training_set_count_q < LIM_TS1) begin
            polling_training_set_count_q <= polling_training_set_count_q + 1'b1;
        end
    end

    assign state_o = state_q;

    ////////////////////////////////////////////////////////////////////////////
    // loopback and completion timers

    logic [CNT_W-1:0] loopback_idle_wait_timer_q;
    logic [CNT_W-1:0] loopback_master_timer_q;
    logic [CNT_W-1:0] completion_timeout_timer_q;
    logic             lbs_run_q;
    logic             lbm_run_q;

    always_ff @(posedge clock_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            lbs_run_q                  <= 1'b0;
            loopback_idle_wait_timer_q <= '0;
            lb_idle_timeout_o          <= 1'b0;
        end else if (lb_slave_start_i) begin
            lbs_run_q                  <= 1'b1;
            loopback_idle_wait_timer_q <= '0;
            lb_idle_timeout_o          <= 1'b0;
        end else if (lbs_run_q) begin
            if (link_event_i.rx_elec_idle || loopback_idle_wait_timer_q == LIM_LBS - 1'b1) begin
                lbs_run_q         <= 1'b0;
                lb_idle_timeout_o <= 1'b1;
            end else begin
                loopback_idle_wait_timer_q <= loopback_idle_wait_timer_q + 1'b1;
            end
        end else begin
            lb_idle_timeout_o <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            lbm_run_q               <= 1'b0;
            loopback_master_timer_q <= '0;
            lb_master_timeout_o     <= 1'b0;
        end else if (lb_master_start_i) begin
            lbm_run_q               <= 1'b1;
            loopback_master_timer_q <= '0;
            lb_master_timeout_o     <= 1'b0;
        end else if (lbm_run_q && loopback_master_timer_q == LIM_LBM - 1'b1) begin
            lbm_run_q           <= 1'b0;
            lb_master_timeout_o <= 1'b1;
        end else begin
            loopback_master_timer_q <= lbm_run_q ? loopback_master_timer_q + 1'b1 : '0;
            lb_master_timeout_o     <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            completion_timeout_timer_q <= '0;
            cpl_timeout_o              <= 1'b0;
        end else if (!cpl_pending_i) begin
            completion_timeout_timer_q <= '0;
            cpl_timeout_o              <= 1'b0;
        end else if (completion_timeout_timer_q == LIM_CPL - 1'b1) begin
            cpl_timeout_o <= 1'b1;
        end else begin
            completion_timeout_timer_q <= completion_timeout_timer_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    AST_REVERSE_ORDER: assert property (@(posedge clock_i) disable iff (!rst_sync_q)
        (flip_lanes_i && !single_lane_i) |=> lane_rx_o.data[0] == $past(serdes_rx_i.data[3]))
        else $error("reversed lane 0 not fed from channel 3");
    AST_STRAIGHT_ORDER: assert property (@(posedge clock_i) disable iff (!rst_sync_q)
        (!flip_lanes_i && !single_lane_i) |=> lane_rx_o.data[3] == $past(serdes_rx_i.data[3]))
        else $error("straight lane 3 not fed from channel 3");
    AST_SINGLE_LANE: assert property (@(posedge clock_i) disable iff (!rst_sync_q)
        single_lane_i |=> !lane_rx_o.valid[1] && !lane_rx_o.valid[3])
        else $error("upper lanes active in single-lane mode");
    AST_TIMER_RESTART: assert property (@(posedge clock_i) disable iff (!rst_sync_q)
        (state_q != $past(state_q)) |-> state_timer_q == '0)
        else $error("state timer not restarted on entry");
    AST_QUIET_EXIT: assert property (@(posedge clock_i) disable iff (!rst_sync_q)
        (state_q == ST_DETECT_QUIET && state_timer_q < LIM_QUIET - 1'b1
         && link_event_i.rx_elec_idle) |=> state_q == ST_DETECT_QUIET)
        else $error("detect quiet left early");
    AST_TS1_GATE: assert property (@(posedge clock_i) disable iff (!rst_sync_q)
        (state_q == ST_POLL_ACTIVE && state_d == ST_POLL_CONFIG)
        |-> polling_training_set_count_q >= LIM_TS1)
        else $error("polling left before all training sets sent");
    AST_DETECT_TO_POLL: assert property (@(posedge clock_i) disable iff (!rst_sync_q)
        (state_q == ST_DETECT_ACTIVE && link_event_i.receiver_found)
        |=> state_q == ST_POLL_ACTIVE)
        else $error("partner found but polling not entered");
    AST_LBM_TIMEOUT: assert property (@(posedge clock_i) disable iff (!rst_sync_q)
        $rose(lb_master_timeout_o) |-> loopback_master_timer_q == LIM_LBM - 1'b1)
        else $error("loopback master timeout at wrong count");
    AST_LBS_TIMEOUT: assert property (@(posedge clock_i) disable iff (!rst_sync_q)
        $rose(lb_idle_timeout_o) |-> $past(lbs_run_q))
        else $error("loopback idle wait ended without running");

endmodule

// [verilog/ltssm_timer_pkg.sv]
// constants and carrier types for lane order and training-state timers
package ltssm_timer_pkg;
    localparam int unsigned CLK_PERIOD_PS = 8000;
    localparam int unsigned LANES         = 4;
    localparam int unsigned LANE_W        = 10;

    // normal figures
    localparam longint unsigned LB_IDLE_WAIT_US    = 1000;
    localparam longint unsigned DETECT_QUIET_US    = 12000;
    localparam longint unsigned POLL_ACTIVE_US     = 24000;
    localparam longint unsigned POLL_CONFIG_US     = 48000;
    localparam longint unsigned CFG_IDLE_US        = 2000;
    localparam longint unsigned CPL_TIMEOUT_US     = 50000;
    localparam longint unsigned LB_MASTER_US       = 100000;
    localparam int unsigned     TS1_COUNT_NORMAL   = 1024;
    // simulation figures
    localparam longint unsigned LB_IDLE_WAIT_SIM_NS = 800;
    localparam longint unsigned DETECT_QUIET_SIM_NS = 800;
    localparam longint unsigned POLL_ACTIVE_SIM_NS  = 1600;
    localparam longint unsigned POLL_CONFIG_SIM_NS  = 3200;
    localparam longint unsigned CFG_IDLE_SIM_NS     = 1200;
    localparam longint unsigned CPL_TIMEOUT_SIM_NS  = 20000;
    localparam longint unsigned LB_MASTER_SIM_NS    = 4000;
    localparam int unsigned     TS1_COUNT_SIM       = 48;

    // least times round up to whole cycles
    function automatic int unsigned ns_to_cyc(input longint unsigned ns);
        longint unsigned c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : int'(c);
    endfunction

    localparam int unsigned LB_IDLE_WAIT_CYC     = ns_to_cyc(LB_IDLE_WAIT_US * 1000);
    localparam int unsigned DETECT_QUIET_CYC     = ns_to_cyc(DETECT_QUIET_US * 1000);
    localparam int unsigned POLL_ACTIVE_CYC      = ns_to_cyc(POLL_ACTIVE_US * 1000);
    localparam int unsigned POLL_CONFIG_CYC      = ns_to_cyc(POLL_CONFIG_US * 1000);
    localparam int unsigned CFG_IDLE_CYC         = ns_to_cyc(CFG_IDLE_US * 1000);
    localparam int unsigned CPL_TIMEOUT_CYC      = ns_to_cyc(CPL_TIMEOUT_US * 1000);
    localparam int unsigned LB_MASTER_CYC        = ns_to_cyc(LB_MASTER_US * 1000);
    localparam int unsigned LB_IDLE_WAIT_SIM_CYC = ns_to_cyc(LB_IDLE_WAIT_SIM_NS);
    localparam int unsigned DETECT_QUIET_SIM_CYC = ns_to_cyc(DETECT_QUIET_SIM_NS);
    localparam int unsigned POLL_ACTIVE_SIM_CYC  = ns_to_cyc(POLL_ACTIVE_SIM_NS);
    localparam int unsigned POLL_CONFIG_SIM_CYC  = ns_to_cyc(POLL_CONFIG_SIM_NS);
    localparam int unsigned CFG_IDLE_SIM_CYC     = ns_to_cyc(CFG_IDLE_SIM_NS);
    localparam int unsigned CPL_TIMEOUT_SIM_CYC  = ns_to_cyc(CPL_TIMEOUT_SIM_NS);
    localparam int unsigned LB_MASTER_SIM_CYC    = ns_to_cyc(LB_MASTER_SIM_NS);

    localparam int unsigned CNT_W = 24;

    typedef enum logic [8:0] {
        ST_DETECT_QUIET  = 9'h001,
        ST_DETECT_ACTIVE = 9'h002,
        ST_POLL_ACTIVE   = 9'h004,
        ST_POLL_CONFIG   = 9'h008,
        ST_CFG_LINKWIDTH = 9'h010,
        ST_CFG_IDLE      = 9'h020,
        ST_L0            = 9'h040,
        ST_RCVRY_LOCK    = 9'h080,
        ST_RCVRY_CFG     = 9'h100
    } train_state_t;

    typedef struct packed {
        logic [LANES-1:0][LANE_W-1:0] data;
        logic [LANES-1:0]             valid;
    } lane_bus_t;

    typedef struct packed {
        logic rx_ts1;
        logic rx_ts2;
        logic rx_idle_set;
        logic rx_elec_idle;
        logic receiver_found;
        logic link_ok;
        logic retrain;
    } link_event_t;
endpackage

// [verification/link_partner_model.sv]
// far-end link partner model: answers training states, drives the serdes channels
`timescale 1ns/1ns
module link_partner_model
    import ltssm_timer_pkg::*;
(
    input  wire logic         clock_i,
    input  wire train_state_t state_i,
    input  wire logic         present_i,
    input  wire logic         respond_i,
    input  wire logic         line_idle_i,
    input  wire logic         retrain_i,
    input  wire train_state_t stop_at_i,
    output lane_bus_t         serdes_rx_o,
    output link_event_t       link_event_o
);
    logic [7:0] tick_q = 8'h00;
    logic       talk;

    // stop_at_i lets a scenario leave one state unanswered so its timer runs out
    assign talk = respond_i && (state_i !== stop_at_i);

    ////////////////////////////////////////////////////////////////////////
    // a fresh word on every channel each cycle, so a stale or swapped lane shows
    always @(negedge clock_i) begin
        tick_q <= tick_q + 8'h01;
        for (int c = 0; c < LANES; c++) begin
            serdes_rx_o.data[c] <= {c[1:0], tick_q};
        end
        serdes_rx_o.valid <= tick_q[3:0] ^ 4'h5;
    end

    ////////////////////////////////////////////////////////////////////////
    // built in a local copy so the output is written once per edge
    always @(negedge clock_i) begin
        link_event_t ev;
        ev                = '0;
        ev.rx_elec_idle   = line_idle_i;
        ev.receiver_found = present_i;
        if (talk) begin
            case (state_i)
                ST_POLL_ACTIVE, ST_RCVRY_LOCK: ev.rx_ts1 = 1'h1;
                ST_POLL_CONFIG: ev.rx_ts2 = 1'h1;
                ST_CFG_LINKWIDTH: ev.link_ok = 1'h1;
                ST_CFG_IDLE, ST_RCVRY_CFG: ev.rx_idle_set = 1'h1;
                ST_L0: ev.retrain = retrain_i;
                default: ;
            endcase
        end
        link_event_o <= ev;
    end
endmodule

// [verification/tb_top.sv]
// self-checking bench for lane order and training-state timers
`timescale 1ns/1ns
module tb_top
    import ltssm_timer_pkg::*;
;
    localparam int L24 = int'(POLL_ACTIVE_SIM_NS / 8);
    localparam int L48 = int'(POLL_CONFIG_SIM_NS / 8);
    localparam int LCI = int'(CFG_IDLE_SIM_NS / 8);
    localparam int LQT = int'(DETECT_QUIET_SIM_NS / 8);
    localparam int LBI = int'(LB_IDLE_WAIT_SIM_NS / 8);
    localparam int LBM = int'(LB_MASTER_SIM_NS / 8);
    localparam int LCP = int'(CPL_TIMEOUT_SIM_NS / 8);

    logic         clk;
    logic         resetn_i  = 1'h0;
    logic         flip      = 1'h0;
    logic         one_lane  = 1'h0;
    logic [1:0]   chan      = 2'h0;
    logic         ts1_sent  = 1'h0;
    logic         lbs_start = 1'h0;
    logic         lbm_start = 1'h0;
    logic         pending   = 1'h0;
    logic         respond   = 1'h0;
    logic         line_idle = 1'h1;
    logic         retrain   = 1'h0;
    logic         present   = 1'h1;
    train_state_t stop_at   = ST_DETECT_ACTIVE;
    lane_bus_t    serdes;
    lane_bus_t    lane_rx;
    link_event_t  link_ev;
    train_state_t state;
    logic         lbi_to;
    logic         lbm_to;
    logic         cpl_to;
    int           budget    = 0;
    int           n_fail    = 0;
    int           checks    = 0;
    train_state_t tst [6]   = '{ST_POLL_ACTIVE, ST_POLL_CONFIG, ST_CFG_LINKWIDTH,
                                ST_CFG_IDLE, ST_RCVRY_LOCK, ST_RCVRY_CFG};
    int           tlim [6]  = '{L24, L48, L24, LCI, L24, L48};

    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    ltssm_timers_lanes #(.SIMULATE(1'h1)) DUT (
        .clock_i            (clk),
        .resetn_i           (resetn_i),
        .flip_lanes_i       (flip),
        .single_lane_i      (one_lane),
        .single_chan_i      (chan),
        .serdes_rx_i        (serdes),
        .link_event_i       (link_ev),
        .ts1_sent_i         (ts1_sent),
        .lb_slave_start_i   (lbs_start),
        .lb_master_start_i  (lbm_start),
        .cpl_pending_i      (pending),
        .lane_rx_o          (lane_rx),
        .state_o            (state),
        .lb_idle_timeout_o  (lbi_to),
        .lb_master_timeout_o(lbm_to),
        .cpl_timeout_o      (cpl_to)
    );

    link_partner_model partner (
        .clock_i     (clk),
        .state_i     (state),
        .present_i   (present),
        .respond_i   (respond),
        .line_idle_i (line_idle),
        .retrain_i   (retrain),
        .stop_at_i   (stop_at),
        .serdes_rx_o (serdes),
        .link_event_o(link_ev)
    );

    // one transmitted set every other cycle while polling, up to the budget
    always @(negedge clk) begin
        if (ts1_sent === 1'h0 && budget > 0 && state === ST_POLL_ACTIVE) begin
            ts1_sent <= 1'h1;
            budget--;
        end else begin
            ts1_sent <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wait_state(input train_state_t st, input logic want, input int bound = 3000);
        for (int i = 0; i < bound && ((state === st) != want); i++) begin
            @(negedge clk);
        end
        if ((state === st) != want) begin
            n_fail++;
            $display("unexpected state wait: expected %0h seen %0h", st, state);
            print_verdict();
        end
    endtask

    // waits for a fresh entry so a stay already under way is never counted
    task automatic measure(input train_state_t st, input int lim);
        int n;
        wait_state(st, 1'h0);
        wait_state(st, 1'h1);
        n = 0;
        while (state === st && n < lim + 9) begin
            n++;
            @(negedge clk);
        end
        check("cycles in state", n, lim);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic lane_case(input logic fl, input logic one, input logic [1:0] ch);
        lane_bus_t s;
        lane_bus_t e;
        flip = fl;
        one_lane = one;
        chan = ch;
        #1;
        s = serdes;
        e = '0;
        for (int n = 0; n < LANES; n++) begin
            if (!one) begin
                e.data[n] = s.data[fl ? LANES - 1 - n : n];
                e.valid[n] = s.valid[fl ? LANES - 1 - n : n];
            end
        end
        if (one) begin
            e.data[0] = s.data[ch];
            e.valid[0] = s.valid[ch];
        end
        @(negedge clk);
        check("logical lanes", lane_rx, e);
    endtask

    task automatic lane_order();
        lane_case(1'h0, 1'h0, 2'h0);
        lane_case(1'h1, 1'h0, 2'h0);
        for (int c = 0; c < 4; c++) begin
            lane_case(c[0], 1'h1, c[1:0]);
        end
        lane_case(1'h0, 1'h0, 2'h0);
    endtask

    task automatic state_timers();
        respond = 1'h1;
        for (int k = 0; k < 6; k++) begin
            stop_at = tst[k];
            retrain = (k > 3);
            budget = 100000;
            measure(tst[k], tlim[k]);
        end
        measure(ST_DETECT_QUIET, LQT);
        measure(ST_DETECT_ACTIVE, 1);
        retrain = 1'h0;
        stop_at = ST_DETECT_ACTIVE;
    endtask

    // no partner: detect must fall back to quiet; a live line cuts quiet short
    task automatic detect_paths();
        respond = 1'h0;
        present = 1'h0;
        wait_state(ST_DETECT_ACTIVE, 1'h1);
        wait_state(ST_DETECT_QUIET, 1'h1, 3);
        line_idle = 1'h0;
        measure(ST_DETECT_QUIET, 1);
        measure(ST_DETECT_ACTIVE, 1);
        line_idle = 1'h1;
        present = 1'h1;
        respond = 1'h1;
    endtask

    task automatic train_to_l0();
        budget = 0;
        wait_state(ST_POLL_ACTIVE, 1'h0);
        wait_state(ST_POLL_ACTIVE, 1'h1);
        budget = 47;
        repeat (110) @(negedge clk);
        check("state after 47 sets", state, ST_POLL_ACTIVE);
        budget = 1;
        wait_state(ST_POLL_CONFIG, 1'h1, 4);
        wait_state(ST_L0, 1'h1, 20);
        retrain = 1'h1;
        wait_state(ST_RCVRY_LOCK, 1'h1, 4);
        retrain = 1'h0;
        wait_state(ST_L0, 1'h1, 10);
    endtask

    task automatic loop_timer(input logic m, input int lo, input int hi);
        int n;
        lbm_start = m;
        lbs_start = !m;
        @(negedge clk);
        lbm_start = 1'h0;
        lbs_start = 1'h0;
        n = 1;
        while (n <= hi && (m ? lbm_to : lbi_to) !== 1'h1) begin
            @(negedge clk);
            n++;
        end
        check("loopback wait", n >= lo && n <= hi, 1'h1);
        @(negedge clk);
        check("loopback pulse width", m ? lbm_to : lbi_to, 1'h0);
    endtask

    task automatic loopback_and_cpl();
        int n;
        line_idle = 1'h0;
        loop_timer(1'h0, LBI - 1, LBI + 1);
        loop_timer(1'h1, LBM - 1, LBM + 1);
        line_idle = 1'h1;
        loop_timer(1'h0, 1, 3);
        // a timer that misses the clear would fire some 1000 cycles early
        pending = 1'h1;
        repeat (1000) @(negedge clk);
        pending = 1'h0;
        @(negedge clk);
        pending = 1'h1;
        n = 0;
        while (cpl_to !== 1'h1 && n < LCP + 5) begin
            @(negedge clk);
            n++;
        end
        check("completion wait", n >= LCP - 1 && n <= LCP + 1, 1'h1);
        repeat (3) @(negedge clk);
        check("completion held", cpl_to, 1'h1);
        pending = 1'h0;
        repeat (2) @(negedge clk);
        check("completion cleared", cpl_to, 1'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(negedge clk);
        resetn_i = 1'h1;
        repeat (3) @(negedge clk);
        lane_order();
        state_timers();
        detect_paths();
        train_to_l0();
        loopback_and_cpl();
        print_verdict();
    end
endmodule
